// file: hdl/flash_write_consts.vh
// flash_write_consts.vh: offsets, fields, encodings and reset values of the indirect-write block
// assumes: included by bare name from hdl/ design files
`ifndef FLASH_WRITE_CONSTS_VH
`define FLASH_WRITE_CONSTS_VH
// register byte offsets
`define OFS_CONTROL 8'h00
`define OFS_DEVICE_CONFIG 8'h04
`define OFS_STATUS 8'h08
`define OFS_FLAG_CLEAR 8'h0C
`define OFS_DATA_LENGTH 8'h10
`define OFS_COMMAND_CONFIG 8'h14
`define OFS_TARGET_ADDRESS 8'h18
`define OFS_DATA_FIFO 8'h20
// control register fields
`define CTL_ENABLE 0
`define CTL_DMA_REQ_EN 2
`define CTL_SAMPLE_SHIFT 4
`define CTL_THR_LO 8
`define CTL_THR_HI 12
`define CTL_ERR_IE 16
`define CTL_DONE_IE 17
`define CTL_THR_IE 18
`define CTL_PRESC_LO 24
`define CTL_PRESC_HI 31
// device config fields
`define DCR_SELECT_HIGH_MIN_TIME_LO 8
`define DCR_SELECT_HIGH_MIN_TIME_HI 10
`define DCR_SIZE_LO 16
`define DCR_SIZE_HI 20
// command config fields
`define CCR_INST_LO 0
`define CCR_INST_HI 7
`define CCR_INSTRUCTION_LANE_MODE_LO 8
`define CCR_INSTRUCTION_LANE_MODE_HI 9
`define CCR_ADDRESS_LANE_MODE_LO 10
`define CCR_ADDRESS_LANE_MODE_HI 11
`define CCR_ADDRESS_WIDTH_FIELD_LO 12
`define CCR_ADDRESS_WIDTH_FIELD_HI 13
`define CCR_DATA_LANE_MODE_LO 24
`define CCR_DATA_LANE_MODE_HI 25
`define CCR_FUNCTION_MODE_FIELD_LO 26
`define CCR_FUNCTION_MODE_FIELD_HI 27
// status bits
`define ST_ERROR 0
`define ST_DONE 1
`define ST_THRESH 2
`define ST_BUSY 5
`define ST_LEVEL_LO 8
`define ST_LEVEL_HI 12
// encodings and reset values
`define FUNCTION_MODE_FIELD_IND_WRITE 2'b00
`define LANE_NONE 2'b00
`define LANE_QUAD 2'b11
`define FOUR_LINE_PROGRAM_COMMAND 8'h32
`define RST_CONTROL 32'h0000_0000
`define RST_DEVICE_CONFIG 32'h0000_0000
`define RST_COMMAND_CONFIG 32'h0000_0000
`define FIFO_DEPTH 5'h10
`endif

// file: hdl/sclk_divider.v
// sclk_divider.v: serial clock generator, one serial cycle per (divisor+1) bus cycles, two for a divisor of zero
// assumes: run held high while the frame may advance; divisor static during a frame
`timescale 1ns/10ps
module sclk_divider (
  input wire pclk, // bus clock
  input wire presetn, // async reset, active low
  input wire run, // count while high, restart when low
  input wire [7:0] div, // prescaler setting
  output wire tick, // one-cycle pulse ending each serial cycle
  output reg sclk_q // serial clock level
);
  reg [7:0] cnt_q;
  wire [7:0] lim;
  wire [7:0] cnt_d;

  ////////////////////////////////////////////////////////////////////////////
  // a setting of zero is run as one so the clock still has a high phase
  assign lim = (div == 8'h00) ? 8'h01 : div;
  assign tick = run && (cnt_q == lim);
  assign cnt_d = (!run || tick) ? 8'h00 : cnt_q + 8'h01;

  // counter and clock level, high in the second part of the cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 8'h00;
      sclk_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      sclk_q <= run && (cnt_d > {1'b0, lim[7:1]});
    end
  end
endmodule // sclk_divider

// file: hdl/serial_flash_indirect_write.v
// serial_flash_indirect_write.v: APB slave and frame engine for indirect flash programming
// assumes: APB master per protocol; flash samples its lines on the rising serial clock
// Function
// - serial clock is bus clock over prescaler+1; a prescaler of 0 gives bus clock over 2
// - threshold flag raised, then data driven
// - memory holds two^(size field+1) bytes
// - select stays high the minimum time between frames
// - frame is instruction, 24-bit address, quad data
// - exactly data-length bytes are sent
// - frame starts once address is written
// - separate error, threshold, complete interrupt enables
// - threshold interrupt lets handler refill FIFO
// - data from software writes or DMA
// - DMA transfer finishes without processor help; stalls if threshold is 8 or more and length exceeds 16 minus threshold
// - complete flag set after last data
//
// Our own choices: the register offsets and register access over APB.
`timescale 1ns/10ps
`include "flash_write_consts.vh"
module serial_flash_indirect_write (
  input wire pclk, // bus clock
  input wire presetn, // async reset, active low
  input wire [7:0] paddr, // APB byte address
  input wire psel, // APB select
  input wire penable, // APB access phase
  input wire pwrite, // APB direction
  input wire [31:0] pwdata, // APB write data
  output reg [31:0] prdata, // APB read data
  output wire pready, // APB ready
  output wire pslverr, // APB error, unmapped offset
  output wire flash_sclk, // serial clock to flash
  output reg flash_cs_n, // chip select, active low
  output reg [3:0] flash_io_out, // data lines driven
  output reg [3:0] flash_io_oe, // data line enables
  output wire irq, // interrupt request, active high
  output wire dma_req // DMA request level
);
  localparam [4:0] S_IDLE = 5'b00001;
  localparam [4:0] S_INST = 5'b00010;
  localparam [4:0] S_ADDR = 5'b00100;
  localparam [4:0] S_DATA = 5'b01000;
  localparam [4:0] S_HOLD = 5'b10000;

  reg [31:0] control_q;
  reg [31:0] device_config_q;
  reg [31:0] data_length_q;
  reg [31:0] command_config_q;
  reg [31:0] target_address_q;
  reg err_q;
  reg done_q;
  reg pend_q;
  reg [4:0] state_q;
  reg [31:0] sh_q;
  reg [5:0] bits_q;
  reg [31:0] remain_q;
  reg loaded_q;
  reg nib_q;
  reg go_q;
  reg [3:0] hold_q;
  reg [31:0] rd_d;
  reg hit;

  wire acc;
  wire wr;
  wire fifo_wr_ready;
  wire fifo_rd_valid;
  wire [7:0] fifo_rd_data;
  wire [4:0] level;
  wire pop;
  wire run;
  wire tick;
  wire sclk_raw;
  wire start;
  wire req;
  wire oob;
  wire thr_flag;
  wire busy;
  wire [1:0] instruction_lane_mode;
  wire [1:0] address_lane_mode;
  wire [1:0] address_width_field;
  wire [1:0] data_lane_mode;
  wire [5:0] size_exp;
  wire [5:0] addr_bits;

  ////////////////////////////////////////////////////////////////////////////
  // bus decode; a data write waits while the FIFO is full
  assign acc = psel && penable;
  assign pready = !(psel && pwrite && (paddr == `OFS_DATA_FIFO) && !fifo_wr_ready);
  assign wr = acc && pwrite && pready;
  assign pslverr = acc && !hit;
  assign instruction_lane_mode = command_config_q[`CCR_INSTRUCTION_LANE_MODE_HI:`CCR_INSTRUCTION_LANE_MODE_LO];
  assign address_lane_mode = command_config_q[`CCR_ADDRESS_LANE_MODE_HI:`CCR_ADDRESS_LANE_MODE_LO];
  assign address_width_field = command_config_q[`CCR_ADDRESS_WIDTH_FIELD_HI:`CCR_ADDRESS_WIDTH_FIELD_LO];
  assign data_lane_mode = command_config_q[`CCR_DATA_LANE_MODE_HI:`CCR_DATA_LANE_MODE_LO];
  assign addr_bits = {1'b0, address_width_field, 3'b000} + 6'h08;
  assign size_exp = {1'b0, device_config_q[`DCR_SIZE_HI:`DCR_SIZE_LO]} + 6'h01;
  assign busy = !state_q[0] && !state_q[4];

  // address outside the 2^(size+1) byte memory is a transfer error
  assign oob = ((target_address_q >> size_exp) != 32'h0000_0000);

  // a frame is requested by the address write, or the command write without address;
  // the request waits a cycle in pend_q so the frame sees the freshly written registers
  assign req = !busy && wr && (((paddr == `OFS_TARGET_ADDRESS) && (address_lane_mode != `LANE_NONE))
    || ((paddr == `OFS_COMMAND_CONFIG)
    && (pwdata[`CCR_ADDRESS_LANE_MODE_HI:`CCR_ADDRESS_LANE_MODE_LO] == `LANE_NONE)));
  assign start = pend_q && control_q[`CTL_ENABLE]
    && (command_config_q[`CCR_FUNCTION_MODE_FIELD_HI:`CCR_FUNCTION_MODE_FIELD_LO] == `FUNCTION_MODE_FIELD_IND_WRITE);

  // threshold flag: enough free room while a write frame runs
  assign thr_flag = busy
    && ((`FIFO_DEPTH - level) > control_q[`CTL_THR_HI:`CTL_THR_LO]);

  // interrupt and DMA request from enabled conditions
  assign irq = (err_q && control_q[`CTL_ERR_IE]) || (done_q && control_q[`CTL_DONE_IE])
    || (thr_flag && control_q[`CTL_THR_IE]);
  assign dma_req = control_q[`CTL_DMA_REQ_EN] && thr_flag;

  // serial clock only runs while a bit is ready; paused while select is high
  assign run = (state_q[1] || state_q[2] || (state_q[3] && loaded_q) || state_q[4]);
  assign flash_sclk = sclk_raw && !state_q[4];
  assign pop = state_q[3] && !loaded_q && go_q && fifo_rd_valid;

  sclk_divider u_div (
    .pclk(pclk),
    .presetn(presetn),
    .run(run),
    .div(control_q[`CTL_PRESC_HI:`CTL_PRESC_LO]),
    .tick(tick),
    .sclk_q(sclk_raw)
  );

  write_fifo u_fifo (
    .pclk(pclk),
    .presetn(presetn),
    .flush(!control_q[`CTL_ENABLE]),
    .wr_valid(wr && (paddr == `OFS_DATA_FIFO)),
    .wr_ready(fifo_wr_ready),
    .wr_data(pwdata[7:0]),
    .rd_valid(fifo_rd_valid),
    .rd_ready(pop),
    .rd_data(fifo_rd_data),
    .level(level)
  );

  ////////////////////////////////////////////////////////////////////////////
  // read mux
  always @* begin
    hit = 1'b1;
    rd_d = 32'h0000_0000;
    case (paddr)
      `OFS_CONTROL: rd_d = control_q;
      `OFS_DEVICE_CONFIG: rd_d = device_config_q;
      `OFS_STATUS: begin
        rd_d[`ST_ERROR] = err_q;
        rd_d[`ST_DONE] = done_q;
        rd_d[`ST_THRESH] = thr_flag;
        rd_d[`ST_BUSY] = busy;
        rd_d[`ST_LEVEL_HI:`ST_LEVEL_LO] = level;
      end
      `OFS_FLAG_CLEAR: rd_d = 32'h0000_0000;
      `OFS_DATA_LENGTH: rd_d = data_length_q;
      `OFS_COMMAND_CONFIG: rd_d = command_config_q;
      `OFS_TARGET_ADDRESS: rd_d = target_address_q;
      `OFS_DATA_FIFO: rd_d = 32'h0000_0000;
      default: hit = 1'b0;
    endcase
  end

  // read data captured in the setup phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rd_d;
    end
  end

  // configuration registers, held while a frame runs except control_q, which is written at any time
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_q <= `RST_CONTROL;
      device_config_q <= `RST_DEVICE_CONFIG;
      data_length_q <= 32'h0000_0000;
      command_config_q <= `RST_COMMAND_CONFIG;
      target_address_q <= 32'h0000_0000;
    end else if (wr) begin
      if (paddr == `OFS_CONTROL) begin
        control_q <= pwdata;
      end
      if (paddr == `OFS_DEVICE_CONFIG && !busy) begin
        device_config_q <= pwdata;
      end
      if (paddr == `OFS_DATA_LENGTH && !busy) begin
        data_length_q <= pwdata;
      end
      if (paddr == `OFS_COMMAND_CONFIG && !busy) begin
        command_config_q <= pwdata;
      end
      if (paddr == `OFS_TARGET_ADDRESS && !busy) begin
        target_address_q <= pwdata;
      end
    end
  end

  // sticky flags, a set in the clearing cycle wins
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      err_q <= (state_q[0] && start && oob)
        || (err_q && !(wr && paddr == `OFS_FLAG_CLEAR && pwdata[`ST_ERROR]));
      done_q <= (busy && tick && ((state_q[3] && nib_q && remain_q == 32'h0000_0001)
        || (bits_q == 6'h01 && !state_q[3] && (data_lane_mode == `LANE_NONE || remain_q == 32'h0000_0000)
        && (state_q[2] || address_lane_mode == `LANE_NONE))))
        || (done_q && !(wr && paddr == `OFS_FLAG_CLEAR && pwdata[`ST_DONE]));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // frame engine: instruction, address, quad data, select high time
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= S_IDLE;
      sh_q <= 32'h0000_0000;
      bits_q <= 6'h00;
      remain_q <= 32'h0000_0000;
      loaded_q <= 1'b0;
      nib_q <= 1'b0;
      go_q <= 1'b0;
      hold_q <= 4'h0;
      pend_q <= 1'b0;
    end else begin
      case (state_q)
        S_IDLE: begin
          pend_q <= req;
          go_q <= 1'b0;
          remain_q <= (data_lane_mode == `LANE_NONE) ? 32'h0000_0000 : data_length_q;
          if (start && !oob) begin
            if (instruction_lane_mode != `LANE_NONE) begin
              state_q <= S_INST;
              sh_q <= {command_config_q[`CCR_INST_HI:`CCR_INST_LO], 24'h00_0000};
              bits_q <= 6'h08;
            end else begin
              state_q <= S_ADDR;
              sh_q <= target_address_q << (6'h20 - addr_bits);
              bits_q <= addr_bits;
            end
          end
        end
        S_INST, S_ADDR: begin
          if (tick) begin
            sh_q <= {sh_q[30:0], 1'b0};
            bits_q <= bits_q - 6'h01;
            if (bits_q == 6'h01) begin
              if (state_q[1] && address_lane_mode != `LANE_NONE) begin
                state_q <= S_ADDR;
                sh_q <= target_address_q << (6'h20 - addr_bits);
                bits_q <= addr_bits;
              end else if (remain_q != 32'h0000_0000) begin
                state_q <= S_DATA;
                loaded_q <= 1'b0;
              end else begin
                state_q <= S_HOLD;
                hold_q <= device_config_q[`DCR_SELECT_HIGH_MIN_TIME_HI:`DCR_SELECT_HIGH_MIN_TIME_LO] + 4'h1;
              end
            end
          end
        end
        S_DATA: begin
          // wait for the threshold or the whole remainder before driving data
          if ((level > control_q[`CTL_THR_HI:`CTL_THR_LO])
              || ({27'h000_0000, level} >= remain_q)) begin
            go_q <= 1'b1;
          end
          if (pop) begin
            sh_q <= {fifo_rd_data, 24'h00_0000};
            loaded_q <= 1'b1;
            nib_q <= 1'b0;
          end else if (tick) begin
            sh_q <= {sh_q[27:0], 4'h0};
            nib_q <= 1'b1;
            if (nib_q) begin
              loaded_q <= 1'b0;
              remain_q <= remain_q - 32'h0000_0001;
              if (remain_q == 32'h0000_0001) begin
                state_q <= S_HOLD;
                hold_q <= device_config_q[`DCR_SELECT_HIGH_MIN_TIME_HI:`DCR_SELECT_HIGH_MIN_TIME_LO] + 4'h1;
              end
            end
          end
        end
        S_HOLD: begin
          // a new request during the high time waits for it to pass
          if (req) begin
            pend_q <= 1'b1;
          end
          if (tick) begin
            hold_q <= hold_q - 4'h1;
            if (hold_q == 4'h1) begin
              state_q <= S_IDLE;
            end
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // pin drive: one line for instruction and address, four for data in quad lane mode, else one
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flash_cs_n <= 1'b1;
      flash_io_out <= 4'h0;
      flash_io_oe <= 4'h0;
    end else begin
      flash_cs_n <= !busy;
      if (state_q[3] && data_lane_mode == `LANE_QUAD) begin
        flash_io_out <= sh_q[31:28];
        flash_io_oe <= loaded_q ? 4'hF : 4'h0;
      end else if (busy) begin
        flash_io_out <= {3'b000, sh_q[31]};
        flash_io_oe <= 4'h1;
      end else begin
        flash_io_out <= 4'h0;
        flash_io_oe <= 4'h0;
      end
    end
  end
endmodule // serial_flash_indirect_write

// file: hdl/write_fifo.v
// write_fifo.v: byte FIFO between the register bus and the serial shifter
// assumes: single clock; writer honours wr_ready, reader honours rd_valid
`timescale 1ns/10ps
`include "flash_write_consts.vh"
module write_fifo (
  input wire pclk, // bus clock
  input wire presetn, // async reset, active low
  input wire flush, // empty the FIFO
  input wire wr_valid, // push request
  output wire wr_ready, // room for a byte
  input wire [7:0] wr_data, // byte to push
  output wire rd_valid, // a byte is held
  input wire rd_ready, // pop request
  output wire [7:0] rd_data, // oldest byte
  output wire [4:0] level // bytes held
);
  reg [7:0] mem_q [0:15];
  reg [3:0] wp_q;
  reg [3:0] rp_q;
  reg [4:0] cnt_q;
  wire push;
  wire pop;

  ////////////////////////////////////////////////////////////////////////////
  assign wr_ready = (cnt_q != `FIFO_DEPTH);
  assign rd_valid = (cnt_q != 5'h00);
  assign push = wr_valid && wr_ready;
  assign pop = rd_valid && rd_ready;
  assign rd_data = mem_q[rp_q];
  assign level = cnt_q;

  // storage, written at the write index
  always @(posedge pclk) begin
    if (push) begin
      mem_q[wp_q] <= wr_data;
    end
  end

  // pointers and fill count
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp_q <= 4'h0;
      rp_q <= 4'h0;
      cnt_q <= 5'h00;
    end else if (flush) begin
      wp_q <= 4'h0;
      rp_q <= 4'h0;
      cnt_q <= 5'h00;
    end else begin
      if (push) begin
        wp_q <= wp_q + 4'h1;
      end
      if (pop) begin
        rp_q <= rp_q + 4'h1;
      end
      cnt_q <= cnt_q + {4'h0, push} - {4'h0, pop};
    end
  end
endmodule // write_fifo

// file: verif/flash_chip_model.sv
// flash_chip_model.sv: write-only serial flash decoding one program frame
// assumes: lines sampled on rising serial clock while selected; never drives back
`timescale 1ns/10ps
module flash_chip_model (
  input wire sclk, // serial clock
  input wire cs_n, // select, active low
  input wire [3:0] io // line levels
);
  logic [7:0] instr;
  logic [23:0] addr;
  logic [7:0] mem [0:15];
  logic [3:0] hi;
  int nbits = 0;
  int nbytes = 0;
  int frames = 0;
  ////////////////////////////////////////////////////////////////////////////////
  // restart decoding at each select
  always @(negedge cs_n) begin
    nbits = 0;
    nbytes = 0;
    frames++;
  end
  // instruction, address on one line, then nibbles high first
  always @(posedge sclk) begin
    if (!cs_n) begin
      if (nbits < 8) instr = {instr[6:0], io[0]};
      else if (nbits < 32) addr = {addr[22:0], io[0]};
      else if (!nbits[0]) hi = io;
      else begin
        mem[nbytes[3:0]] = {hi, io};
        nbytes++;
      end
      nbits++;
    end
  end
endmodule // flash_chip_model

// file: verif/flash_write_asserts.sv
// flash_write_asserts.sv: port-level checks on the indirect-write block
// assumes: bound to serial_flash_indirect_write; prescaler 2 or more, select hold 0
`timescale 1ns/10ps
module flash_write_asserts (
  input wire pclk, // bus clock
  input wire presetn, // reset, active low
  input wire [7:0] paddr, // byte address
  input wire psel, // select
  input wire penable, // access phase
  input wire pwrite, // direction
  input wire [31:0] pwdata, // write data
  input wire [31:0] prdata, // read data
  input wire pready, // ready
  input wire pslverr, // error
  input wire flash_sclk, // serial clock
  input wire flash_cs_n, // select, active low
  input wire [3:0] flash_io_out, // line values
  input wire [3:0] flash_io_oe, // line enables
  input wire irq, // interrupt
  input wire dma_req // dma request
);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////////////////////
  // serial side
  sclk_when_idle_a: assert property (flash_cs_n |-> !flash_sclk)
    else $error("serial clock runs while deselected");
  lanes_quiet_a: assert property (flash_cs_n |-> flash_io_oe == 4'h0)
    else $error("lines driven while deselected");
  lane_pattern_a: assert property (flash_io_oe inside {4'h0, 4'h1, 4'hf})
    else $error("illegal line enable pattern");
  select_hold_a: assert property ($rose(flash_cs_n) |-> flash_cs_n [*3])
    else $error("select high time too short");
  clock_after_select_a: assert property ($fell(flash_cs_n) |-> ##[1:600] flash_sclk)
    else $error("frame did not clock after select");
  data_setup_a: assert property ($rose(flash_sclk) |-> $stable(flash_io_out))
    else $error("lines changed on serial clock rise");
  driven_when_clocked_a: assert property (flash_sclk |-> flash_io_oe != 4'h0)
    else $error("serial clock without driven line");
  // bus side
  error_in_access_a: assert property (pslverr |-> psel && penable)
    else $error("bus error outside access phase");
  wait_fifo_only_a: assert property (!pready |-> psel && pwrite && paddr == 8'h20)
    else $error("wait state outside data port write");
endmodule // flash_write_asserts

bind serial_flash_indirect_write flash_write_asserts chk (
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .flash_sclk(flash_sclk), .flash_cs_n(flash_cs_n), .flash_io_out(flash_io_out),
  .flash_io_oe(flash_io_oe), .irq(irq), .dma_req(dma_req)
);

// file: verif/serial_flash_indirect_write_test.sv
// serial_flash_indirect_write_test.sv: register table, frames, dma, error and reset
// assumes: consts header on the include path; lines pulled up when released
`timescale 1ns/10ps
`include "flash_write_consts.vh"
module serial_flash_indirect_write_test;
  typedef struct packed {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] e; logic x;} row_t;
  logic pclk, presetn, psel, penable, pwrite, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, rd;
  wire [31:0] prdata;
  wire pready, pslverr, flash_sclk, flash_cs_n, irq, dma_req;
  wire [3:0] flash_io_out, flash_io_oe, io_w;
  int miscompares = 0, n_compared = 0, cyc = 0, last = 0, per = 0, i, f0;
  row_t rows [0:13] = '{
    '{0, `OFS_CONTROL, 0, `RST_CONTROL, 0}, '{0, `OFS_DEVICE_CONFIG, 0, `RST_DEVICE_CONFIG, 0},
    '{0, `OFS_COMMAND_CONFIG, 0, `RST_COMMAND_CONFIG, 0},
    '{1, `OFS_DEVICE_CONFIG, 32'h0019_0000, 0, 0}, '{0, `OFS_DEVICE_CONFIG, 0, 32'h0019_0000, 0},
    '{1, `OFS_CONTROL, 32'h0206_0301, 0, 0},
    '{0, `OFS_CONTROL, 0, 32'h0206_0301, 0},
    '{1, `OFS_DATA_LENGTH, 32'h0000_0005, 0, 0}, '{0, `OFS_DATA_LENGTH, 0, 32'h0000_0005, 0},
    '{1, `OFS_COMMAND_CONFIG, 32'h0300_2532, 0, 0}, '{0, `OFS_COMMAND_CONFIG, 0, 32'h0300_2532, 0},
    '{1, 8'h30, 32'h0000_ffff, 0, 1}, '{0, 8'h30, 0, 0, 1}, '{0, `OFS_FLAG_CLEAR, 0, 0, 0}};
  assign io_w = (flash_io_out & flash_io_oe) | ~flash_io_oe;
  serial_flash_indirect_write DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .flash_sclk(flash_sclk), .flash_cs_n(flash_cs_n),
    .flash_io_out(flash_io_out), .flash_io_oe(flash_io_oe), .irq(irq), .dma_req(dma_req));
  flash_chip_model flash (.sclk(flash_sclk), .cs_n(flash_cs_n), .io(io_w));
  ////////////////////////////////////////////////////////////////////////////////
  // clock, cycle count and serial period
  initial begin
    pclk = 0;
    forever #4 pclk = ~pclk;
  end
  always @(posedge pclk) cyc++;
  always @(posedge flash_sclk) begin
    per = cyc - last;
    last = cyc;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // one bus transfer, held until ready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1 && ++n < 300);
    if (n >= 300) miscompares++;
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic wait_idle;
    int n;
    n = 0;
    do apb(0, `OFS_STATUS, 0); while (rd[`ST_BUSY] !== 0 && ++n < 200);
    if (n >= 200) miscompares++;
    @(negedge pclk);
  endtask
  task automatic wrap_up;
    $display("comparisons %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #200000;
    miscompares++;
    wrap_up;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata, presetn} = 0;
    repeat (4) @(posedge pclk);
    check({flash_cs_n, flash_sclk, flash_io_oe, irq, dma_req, pready}, 9'h101);
    presetn <= 1;
    foreach (rows[k]) begin
      apb(rows[k].w, rows[k].a, rows[k].d);
      check(err, rows[k].x);
      if (!rows[k].w) check(rd, rows[k].e);
    end
    $display("end of register rows");
    // write enable with no address, then erase of the target sector
    apb(1, `OFS_COMMAND_CONFIG, 32'h0000_0106);
    wait_idle;
    check({flash.instr, flash.nbits[7:0]}, 16'h0608);
    apb(1, `OFS_COMMAND_CONFIG, 32'h0000_25d8);
    apb(1, `OFS_TARGET_ADDRESS, 32'h0000_0123);
    wait_idle;
    check({flash.instr, flash.addr}, 32'hd800_0123);
    check(flash.nbits, 32);
    apb(1, `OFS_FLAG_CLEAR, 32'h0000_0002);
    apb(1, `OFS_COMMAND_CONFIG, 32'h0300_2532);
    $display("end of command frames");
    // software frame, five bytes
    apb(1, `OFS_TARGET_ADDRESS, 32'h0000_0123);
    apb(0, `OFS_STATUS, 0);
    check({rd[`ST_BUSY], rd[`ST_THRESH], rd[`ST_DONE]}, 3'b110);
    check(irq, 1);
    for (i = 0; i < 5; i++) apb(1, `OFS_DATA_FIFO, 32'h0000_00a0 + i);
    wait_idle;
    check(flash.instr, `FOUR_LINE_PROGRAM_COMMAND);
    check(flash.addr, 24'h00_0123);
    check(flash.nbytes, 5);
    for (i = 0; i < 5; i++) check(flash.mem[i], 8'ha0 + i);
    check(per, 3);
    check({rd[`ST_DONE], flash_cs_n, irq}, 3'b111);
    apb(1, `OFS_FLAG_CLEAR, 32'h0000_0002);
    @(negedge pclk);
    check(irq, 0);
    $display("end of software frame");
    // dma frame, eight bytes, started right after the last
    apb(1, `OFS_CONTROL, 32'h0206_0305);
    apb(1, `OFS_DATA_LENGTH, 32'h0000_0008);
    check(dma_req, 0);
    apb(1, `OFS_TARGET_ADDRESS, 32'h0000_0000);
    for (i = 0, f0 = 0; i < 8 && f0 < 2000; f0++) begin
      @(negedge pclk);
      if (dma_req === 1) begin
        apb(1, `OFS_DATA_FIFO, 32'h0000_0050 + i);
        i++;
      end
    end
    wait_idle;
    check(flash.nbytes, 8);
    for (i = 0; i < 8; i++) check(flash.mem[i], 8'h50 + i);
    $display("end of dma frame");
    // out-of-range address raises error, no frame
    apb(1, `OFS_DEVICE_CONFIG, 32'h000f_0000);
    apb(1, `OFS_CONTROL, 32'h0201_0301);
    f0 = flash.frames;
    apb(1, `OFS_TARGET_ADDRESS, 32'h0001_0000);
    wait_idle;
    check({rd[`ST_ERROR], irq}, 2'b11);
    check(flash.frames, f0);
    $display("end of range error");
    // full FIFO holds the data write back until a byte leaves, then reset in mid-frame
    apb(1, `OFS_TARGET_ADDRESS, 32'h0000_fff0);
    for (i = 0; i < 17; i++) apb(1, `OFS_DATA_FIFO, i);
    apb(0, `OFS_STATUS, 0);
    check(rd[`ST_LEVEL_HI:`ST_LEVEL_LO], 16);
    presetn <= 0;
    @(negedge pclk);
    check({flash_cs_n, flash_io_oe, irq}, 6'h20);
    @(posedge pclk);
    presetn <= 1;
    apb(0, `OFS_CONTROL, 0);
    check(rd, `RST_CONTROL);
    $display("end of reset test");
    wrap_up;
  end
endmodule // serial_flash_indirect_write_test
